/* File: dbg_trig_pkg.sv */
package dbg_trig_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_TRIGGER_SETUP = 8'h00;
  localparam logic [7:0] ADDR_CAPTURE_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DEBUG_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_FIFO_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_FIFO_LOW = 8'h10;
  // trigger setup fields
  localparam int TS_QUAL_BIT = 7;
  localparam int TS_BEGIN_BIT = 6;
  localparam logic [7:0] TS_WRITE_MASK = 8'hCF;
  localparam logic [7:0] TS_RESET = 8'h00;
  // debug control fields
  localparam int DC_ENABLE_BIT = 7;
  localparam int DC_ARM_BIT = 6;
  localparam logic [7:0] DC_RESET = 8'h00;
  // status fields
  localparam int ST_AF_BIT = 7;
  localparam int ST_BF_BIT = 6;
  localparam int ST_CAPTURE_ACTIVE_FLAG_BIT = 5;
  // fifo
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] CNT_FULL = 4'h8;
  // trigger modes
  localparam logic [3:0] MODE_A_ONLY = 4'h0;
  localparam logic [3:0] MODE_A_OR_B = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] MODE_EVENT_B = 4'h3;
  localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
  localparam logic [3:0] MODE_A_AND_B = 4'h5;
  localparam logic [3:0] MODE_A_AND_NOT_B = 4'h6;
  localparam logic [3:0] MODE_INSIDE = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE = 4'h8;

  typedef struct packed {
    logic access;
    logic executed;
    logic [15:0] address;
    logic [7:0] data;
  } bus_obs_t;

  typedef enum logic [1:0] {
    RUN_IDLE,
    RUN_WAIT_A,
    RUN_WAIT_TRIG,
    RUN_STORE
  } run_state_t;
endpackage

/* File: debug_trigger_status_unit.sv */
// Contract
// - setup readable always, written only unarmed
// - setup bits 4 and 5 read zero
// - qualify set: trigger only on executed opcode
// - begin bit selects begin or end trace
// - event-only modes always begin trace
// - mode field decodes nine comparator modes
// - modes 7, 8 inside and outside range
// - status register ignores writes
// - A flag clears at start, sets on match
// - B flag clears at start, sets on match
// - armed flag mirrors capture enable
// - armed sets on arm, clears at end
// - begin ends on full, end on trigger
// - writing zero to enables stops run
// - valid count clears at start, counts words
// - valid count not decremented by reads
// - low byte read advances, high does not
// - enable refused while device secured
// - qualify select unchanged by break requests
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module debug_trigger_status_unit (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu bus observation and comparators
  input wire dbg_trig_pkg::bus_obs_t bus_obs,
  input wire logic [15:0] comp_a_value,
  input wire logic [15:0] comp_b_value,
  input wire logic mcu_secure,
  // status out
  output logic capture_armed,
  output logic run_done
);
  logic [7:0] trigger_setup;
  logic [7:0] debug_control_reg;
  logic comp_a_match_flag;
  logic comp_b_hit_flag;
  logic [3:0] fifo_valid_words;
  logic [15:0] fifo_mem [dbg_trig_pkg::FIFO_DEPTH];
  logic [2:0] wr_ptr;
  logic [2:0] rd_ptr;
  dbg_trig_pkg::run_state_t state;
  dbg_trig_pkg::run_state_t next_state;

  // bus decode
  // effects land on the edge that completes the access
  wire acc = psel && penable && pready && pclk_en;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_ts = paddr == dbg_trig_pkg::ADDR_TRIGGER_SETUP;
  wire hit_st = paddr == dbg_trig_pkg::ADDR_CAPTURE_STATUS;
  wire hit_dc = paddr == dbg_trig_pkg::ADDR_DEBUG_CONTROL;
  wire hit_fh = paddr == dbg_trig_pkg::ADDR_FIFO_HIGH;
  wire hit_fl = paddr == dbg_trig_pkg::ADDR_FIFO_LOW;
  wire mapped = hit_ts || hit_st || hit_dc || hit_fh || hit_fl;

  wire dbg_en = debug_control_reg[dbg_trig_pkg::DC_ENABLE_BIT];
  wire arm = debug_control_reg[dbg_trig_pkg::DC_ARM_BIT];
  wire [3:0] mode = trigger_setup[3:0];
  wire qual = trigger_setup[dbg_trig_pkg::TS_QUAL_BIT];
  wire begin_sel = trigger_setup[dbg_trig_pkg::TS_BEGIN_BIT];

  // comparator matches, qualified by opcode execution
  wire raw_a = bus_obs.access && bus_obs.address == comp_a_value;
  wire raw_b = bus_obs.access && bus_obs.address == comp_b_value;
  wire ok = !qual || bus_obs.executed;
  wire match_a = raw_a && ok;
  wire match_b = raw_b && ok;
  wire in_rng = bus_obs.access && bus_obs.address >= comp_a_value &&
    bus_obs.address <= comp_b_value && ok;
  wire out_rng = bus_obs.access && (bus_obs.address < comp_a_value ||
    bus_obs.address > comp_b_value) && ok;
  // data match in full modes uses the data byte against b low byte
  wire data_b = bus_obs.data == comp_b_value[7:0];

  function automatic logic event_mode(input logic [3:0] m);
    event_mode = m == dbg_trig_pkg::MODE_EVENT_B ||
      m == dbg_trig_pkg::MODE_A_THEN_EVENT_B;
  endfunction

  wire is_begin = begin_sel || event_mode(mode);

  // trigger decode per mode; sequenced modes wait for a first
  logic trig;
  logic needs_a_first;
  always_comb begin
    trig = 1'b0;
    needs_a_first = 1'b0;
    case (mode)
      dbg_trig_pkg::MODE_A_ONLY: trig = match_a;
      dbg_trig_pkg::MODE_A_OR_B: trig = match_a || match_b;
      dbg_trig_pkg::MODE_A_THEN_B: begin
        trig = match_b;
        needs_a_first = 1'b1;
      end
      dbg_trig_pkg::MODE_EVENT_B: trig = match_b;
      dbg_trig_pkg::MODE_A_THEN_EVENT_B: begin
        trig = match_b;
        needs_a_first = 1'b1;
      end
      dbg_trig_pkg::MODE_A_AND_B: trig = match_a && data_b;
      dbg_trig_pkg::MODE_A_AND_NOT_B: trig = match_a && !data_b;
      dbg_trig_pkg::MODE_INSIDE: trig = in_rng;
      dbg_trig_pkg::MODE_OUTSIDE: trig = out_rng;
      default: trig = 1'b0;
    endcase
  end

  wire running = state != dbg_trig_pkg::RUN_IDLE;
  wire fifo_full = fifo_valid_words == dbg_trig_pkg::CNT_FULL;
  wire event_store = event_mode(mode) ? match_b : bus_obs.access;
  wire store = running && bus_obs.access && event_store &&
    (state == dbg_trig_pkg::RUN_STORE || !is_begin) &&
    (!is_begin || !fifo_full);
  wire [15:0] store_word = event_mode(mode) ? {8'h00, bus_obs.data} :
    bus_obs.address;
  wire start = wr && hit_dc && pwdata[dbg_trig_pkg::DC_ARM_BIT] &&
    pwdata[dbg_trig_pkg::DC_ENABLE_BIT] && !mcu_secure && !running;
  // manual stop when either control written zero
  wire stop = wr && hit_dc && (!pwdata[dbg_trig_pkg::DC_ARM_BIT] ||
    !pwdata[dbg_trig_pkg::DC_ENABLE_BIT]);
  wire fill_done = store &&
    fifo_valid_words == dbg_trig_pkg::CNT_FULL - 4'h1;
  // begin trace ends on full, end trace on trigger
  wire finish = running && !stop &&
    ((is_begin && fill_done) ||
     (!is_begin && state == dbg_trig_pkg::RUN_WAIT_TRIG && trig));

  always_comb begin
    next_state = state;
    case (state)
      dbg_trig_pkg::RUN_IDLE:
        if (start) begin
          next_state = needs_a_first ? dbg_trig_pkg::RUN_WAIT_A :
            dbg_trig_pkg::RUN_WAIT_TRIG;
        end
      dbg_trig_pkg::RUN_WAIT_A:
        if (match_a) begin
          next_state = dbg_trig_pkg::RUN_WAIT_TRIG;
        end
      dbg_trig_pkg::RUN_WAIT_TRIG:
        if (trig && is_begin) begin
          next_state = dbg_trig_pkg::RUN_STORE;
        end
      dbg_trig_pkg::RUN_STORE: next_state = state;
      default: next_state = dbg_trig_pkg::RUN_IDLE;
    endcase
    if (stop || finish) begin
      next_state = dbg_trig_pkg::RUN_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dbg_trig_pkg::RUN_IDLE;
    end else if (pclk_en) begin
      state <= next_state;
    end
  end

  // setup only writable while unarmed; bits 4,5 masked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_setup <= dbg_trig_pkg::TS_RESET;
    end else if (wr && hit_ts && !arm) begin
      trigger_setup <= pwdata[7:0] & dbg_trig_pkg::TS_WRITE_MASK;
    end
  end

  // control: arm drops at run end; enable refused when secured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_control_reg <= dbg_trig_pkg::DC_RESET;
    end else if (wr && hit_dc) begin
      debug_control_reg <= pwdata[7:0];
      debug_control_reg[dbg_trig_pkg::DC_ENABLE_BIT] <=
        pwdata[dbg_trig_pkg::DC_ENABLE_BIT] && !mcu_secure;
      debug_control_reg[dbg_trig_pkg::DC_ARM_BIT] <=
        pwdata[dbg_trig_pkg::DC_ARM_BIT] &&
        pwdata[dbg_trig_pkg::DC_ENABLE_BIT] && !mcu_secure;
    end else if (pclk_en && finish) begin
      debug_control_reg[dbg_trig_pkg::DC_ARM_BIT] <= 1'b0;
    end
  end

  // flags: start clears, a match sets the same edge it is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_a_match_flag <= 1'b0;
      comp_b_hit_flag <= 1'b0;
      fifo_valid_words <= 4'h0;
      wr_ptr <= 3'h0;
    end else if (pclk_en) begin
      if (start) begin
        comp_a_match_flag <= 1'b0;
        comp_b_hit_flag <= 1'b0;
        fifo_valid_words <= 4'h0;
        wr_ptr <= 3'h0;
      end else begin
        if (running && match_a) comp_a_match_flag <= 1'b1;
        if (running && match_b) comp_b_hit_flag <= 1'b1;
        if (store) begin
          // end trace wraps: count saturates at eight
          wr_ptr <= wr_ptr + 3'h1;
          if (fifo_valid_words != dbg_trig_pkg::CNT_FULL) begin
            fifo_valid_words <= fifo_valid_words + 4'h1;
          end
        end
      end
    end
  end

  // end trace keeps filling circularly over the oldest word
  always_ff @(posedge pclk) begin
    if (pclk_en && store) begin
      fifo_mem[wr_ptr] <= store_word;
    end
  end

  // low byte read advances the read pointer; never while running
  wire adv = rd && hit_fl && !running;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr <= 3'h0;
    end else if (start) begin
      rd_ptr <= 3'h0;
    end else if (pclk_en && store && fifo_full) begin
      // a wrap overwrites the oldest word, so reading starts after it
      rd_ptr <= wr_ptr + 3'h1;
    end else if (adv) begin
      rd_ptr <= rd_ptr + 3'h1;
    end
  end

  // read mux; status has no write path at all
  wire [7:0] status_byte = {comp_a_match_flag, comp_b_hit_flag,
    arm && dbg_en, 1'b0, fifo_valid_words};
  wire [15:0] fifo_word = fifo_mem[rd_ptr];
  wire [7:0] rd_byte = hit_ts ? trigger_setup :
    hit_st ? status_byte :
    hit_dc ? debug_control_reg :
    hit_fh ? fifo_word[15:8] :
    hit_fl ? fifo_word[7:0] : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      capture_armed <= 1'b0;
      run_done <= 1'b0;
    end else if (pclk_en) begin
      // one wait state: ready is registered at the end of the first access cycle, high in the second
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= {24'h000000, rd_byte};
      capture_armed <= next_state != dbg_trig_pkg::RUN_IDLE;
      run_done <= finish;
    end
  end

  property p_setup_locked;
    @(posedge pclk) disable iff (!presetn)
    arm |=> $stable(trigger_setup);
  endproperty
  a_setup_locked: assert property (p_setup_locked)
    else $error("setup changed while armed");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
    trigger_setup[5:4] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved setup bits nonzero");

  property p_start_clears;
    @(posedge pclk) disable iff (!presetn)
    start |=> !comp_a_match_flag && !comp_b_hit_flag &&
      fifo_valid_words == 4'h0;
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("status not cleared at start");

  property p_a_sets;
    @(posedge pclk) disable iff (!presetn)
    pclk_en && running && match_a && !start |=> comp_a_match_flag;
  endproperty
  a_a_sets: assert property (p_a_sets)
    else $error("a flag missed match");

  property p_b_sets;
    @(posedge pclk) disable iff (!presetn)
    pclk_en && running && match_b && !start |=> comp_b_hit_flag;
  endproperty
  a_b_sets: assert property (p_b_sets)
    else $error("b flag missed match");

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
    stop |=> !running && !status_byte[dbg_trig_pkg::ST_CAPTURE_ACTIVE_FLAG_BIT];
  endproperty
  a_stop: assert property (p_stop)
    else $error("run not stopped");

  property p_count_max;
    @(posedge pclk) disable iff (!presetn)
    fifo_valid_words <= dbg_trig_pkg::CNT_FULL;
  endproperty
  a_count_max: assert property (p_count_max)
    else $error("count above eight");

  property p_count_hold;
    @(posedge pclk) disable iff (!presetn)
    !running && !start |=> $stable(fifo_valid_words);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("count moved while idle");

  property p_secure;
    @(posedge pclk) disable iff (!presetn)
    mcu_secure && wr && hit_dc |=> !dbg_en;
  endproperty
  a_secure: assert property (p_secure)
    else $error("enable set while secured");

  property p_begin_full;
    @(posedge pclk) disable iff (!presetn)
    pclk_en && is_begin && fill_done && running && !stop |=> !running;
  endproperty
  a_begin_full: assert property (p_begin_full)
    else $error("begin run did not end on full");

  c_start: cover property (@(posedge pclk) start);
  c_finish: cover property (@(posedge pclk) finish);
  c_full: cover property (@(posedge pclk) fifo_full);
  c_stop: cover property (@(posedge pclk) stop && running);
endmodule
`default_nettype wire

/* File: cpu_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  // clock
  input wire logic pclk,
  // observed cpu bus
  output var dbg_trig_pkg::bus_obs_t bus_obs
);
  initial bus_obs = '0;
  // one access, then idle with inverted address so nothing stale repeats
  task automatic access(input logic [15:0] a, input logic ex);
    @(posedge pclk);
    bus_obs <= '{1'b1, ex, a, a[7:0]};
    @(posedge pclk);
    bus_obs <= '{1'b0, 1'b0, ~a, ~a[7:0]};
  endtask
endmodule
`default_nettype wire

/* File: debug_trigger_status_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module debug_trigger_status_unit_tb;
  localparam logic [15:0] CA = 16'h8000;
  localparam logic [15:0] CB = 16'h8010;
  logic pclk, presetn, psel, penable, pwrite, mcu_secure;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr, capture_armed, run_done;
  logic pclk_en;
  logic [15:0] addr_r;
  logic [15:0] words [8];
  dbg_trig_pkg::bus_obs_t bus_obs;
  logic [7:0] rd;
  logic err;
  logic [31:0] seed = 32'h62;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] ts_tab [14] = '{8'h00, 8'h00, 8'h01, 8'h80, 8'h80,
    8'h07, 8'h07, 8'h08, 8'h08, 8'h03, 8'h02, 8'h04, 8'h05, 8'h06};
  logic [15:0] a_tab [14] = '{CA, CB, CB, CA, CA, 16'h8008, 16'h9000,
    16'h9000, 16'h8008, CB, CA, CA, CA, CA};
  logic ex_tab [14] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0,
    1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

  debug_trigger_status_unit debug_trigger_status_unit_i (
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_obs(bus_obs), .comp_a_value(CA), .comp_b_value(CB),
    .mcu_secure(mcu_secure), .capture_armed(capture_armed),
    .run_done(run_done));
  cpu_bus_model cpu_bus_model_i (.pclk(pclk), .bus_obs(bus_obs));

  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // single access from idle; a sequenced mode cannot fire on one access
  function automatic logic hit_exp(logic [7:0] ts, logic [15:0] a,
    logic ex);
    if (ts[7] && !ex) return 1'b0;
    case (ts[3:0])
      4'h0: return a == CA;
      4'h1: return a == CA || a == CB;
      4'h5: return a == CA && a[7:0] == CB[7:0];
      4'h6: return a == CA && a[7:0] != CB[7:0];
      4'h7: return a >= CA && a <= CB;
      4'h8: return a < CA || a > CB;
      default: return 1'b0;
    endcase
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // disarm, set up, arm, one access, see whether the run ended
  task automatic trig(input logic [7:0] ts, input logic [15:0] a,
    input logic ex);
    apb(1'b1, 8'h08, 8'h00);
    apb(1'b1, 8'h00, ts);
    apb(1'b1, 8'h08, 8'hC0);
    cpu_bus_model_i.access(a, ex);
    @(posedge pclk);
    check("run done", {7'h00, hit_exp(ts, a, ex)},
      {7'h00, run_done});
    repeat (2) @(posedge pclk);
    check("armed after access", {7'h00, ~hit_exp(ts, a, ex)},
      {7'h00, capture_armed});
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    mcu_secure = 1'b0;
    pclk_en = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 8'h00);
    check("setup reset", 8'h00, rd);
    apb(1'b0, 8'h04, 8'h00);
    check("status reset", 8'h00, rd);
    apb(1'b1, 8'h00, 8'hFF);
    apb(1'b0, 8'h00, 8'h00);
    check("setup mask", 8'hCF, rd);
    apb(1'b1, 8'h04, 8'hFF);
    apb(1'b0, 8'h04, 8'h00);
    check("status write", 8'h00, rd);
    apb(1'b0, 8'h40, 8'h00);
    check("unmapped error", 8'h01, {7'h00, err});
    $display("test registers done");
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b1, 8'h08, 8'hC0);
    apb(1'b0, 8'h04, 8'h00);
    check("status armed", 8'h20, rd);
    apb(1'b1, 8'h00, 8'h8F);
    apb(1'b0, 8'h00, 8'h00);
    check("setup locked", 8'h00, rd);
    apb(1'b1, 8'h08, 8'h80);
    apb(1'b0, 8'h04, 8'h00);
    check("manual stop", 8'h00, rd);
    apb(1'b1, 8'h08, 8'h00);
    mcu_secure <= 1'b1;
    apb(1'b1, 8'h08, 8'hC0);
    apb(1'b0, 8'h08, 8'h00);
    check("secured arm", 8'h00, rd);
    mcu_secure <= 1'b0;
    // clock enable low: a matching access must leave the run alone
    apb(1'b1, 8'h08, 8'hC0);
    pclk_en <= 1'b0;
    cpu_bus_model_i.access(CA, 1'b0);
    repeat (2) @(posedge pclk);
    pclk_en <= 1'b1;
    check("frozen armed", 8'h01, {7'h00, capture_armed});
    apb(1'b0, 8'h04, 8'h00);
    check("frozen status", 8'h20, rd);
    $display("test arm done");
    for (int i = 0; i < 14; i++) begin
      trig(ts_tab[i], a_tab[i], ex_tab[i]);
      apb(1'b0, 8'h04, 8'h00);
      if (i == 0) check("a flag", 8'h80, rd & 8'hC0);
      if (i == 2) check("b flag", 8'h40, rd & 8'h40);
    end
    for (int i = 0; i < 4; i++) begin
      trig({4'h0, 4'h9 + 4'(xs() % 7)}, CA, 1'b0);
    end
    $display("test modes done");
    apb(1'b1, 8'h08, 8'h00);
    apb(1'b1, 8'h00, 8'h40);
    apb(1'b1, 8'h08, 8'hC0);
    cpu_bus_model_i.access(CA, 1'b0);
    for (int i = 0; i < 24 && capture_armed === 1'b1; i++) begin
      addr_r = {4'h0, 12'(xs())};
      if (i < 8) words[i] = addr_r;
      cpu_bus_model_i.access(addr_r, 1'b1);
    end
    repeat (3) @(posedge pclk);
    apb(1'b0, 8'h04, 8'h00);
    check("full count", 8'h08, rd & 8'h2F);
    // host tracks the words left itself, count stays put
    for (int left = 8; left > 5; left--) begin
      apb(1'b0, 8'h0C, 8'h00);
      check("fifo high", words[8 - left][15:8], rd);
      apb(1'b0, 8'h10, 8'h00);
      check("fifo low", words[8 - left][7:0], rd);
    end
    apb(1'b0, 8'h04, 8'h00);
    check("count kept", 8'h08, rd & 8'h0F);
    $display("test begin trace done");
    results();
  end
endmodule
`default_nettype wire
